// [pcmc_consts.svh]
// register map, field positions, reset values and counts of the power/clock mode block
// Summary of operation
// RL1: modulator clock is the master clock divided by two, four, eight or sixteen.
// RL2: strap low selects a CMOS master clock, strap high selects the crystal.
// RL3: LVDS clock only with strap high and bits 7:6 at 0x15 selecting it.
// RL4: five software power states: fast, medium, low power, standby, power-down.
// RL5: power-down stops every block, loses registers, leaves only on the wake code.
// RL6: standby stops analog clocking, keeps digital regulator and all register values.
// RL7: continuous read results are twenty-four or sixteen bits long.
// RL8: status bits are appended to each result when enabled.
// RL9: conversion data streams out each frame without a write per result.
// RL10: single conversion mode converts once, then drops to standby itself.
// RL11: one-shot mode converts once per host timed pulse.
// RL12: continuous conversion mode keeps the modulator converting without a gap.
// RL13: duty-cycled mode rests in standby for the programmed interval after each conversion.
// RL14: a one then sixty-three zeros on data input with select low wakes the device.
`ifndef PCMC_CONSTS_SVH
`define PCMC_CONSTS_SVH
`define PCMC_ADDR_PWR_CLK 7'h15
`define PCMC_ADDR_IFMT    7'h16
`define PCMC_ADDR_CONV    7'h17
`define PCMC_ADDR_DUTY    7'h18
`define PCMC_ADDR_STAT    7'h19
`define PCMC_PWR_CLK_RST  8'h00
`define PCMC_IFMT_RST     8'h00
`define PCMC_CONV_RST     8'h00
`define PCMC_DUTY_RST     8'h04
`define PCMC_SRC_MSB      7
`define PCMC_SRC_LSB      6
`define PCMC_DIV_MSB      5
`define PCMC_DIV_LSB      4
`define PCMC_PST_MSB      2
`define PCMC_PST_LSB      0
`define PCMC_MODE_MSB     1
`define PCMC_MODE_LSB     0
`define PCMC_SRC_LVDS     2'h3
`define PCMC_IF_LEN16     0
`define PCMC_IF_STAT      1
`define PCMC_IF_CRD       2
`define PCMC_WORD_LAST    5'h0F
`define PCMC_CMD_LAST     5'h07
`define PCMC_WAKE_ZEROS   6'h3F
`define PCMC_CONV_TICKS   8'h20
`endif

// [pcmc_pkg.sv]
// types shared by the power/clock mode block
package pcmc_pkg;
  typedef enum logic [2:0] {
    PCMC_PS_FAST = 3'h0,
    PCMC_PS_MED  = 3'h1,
    PCMC_PS_LOW  = 3'h2,
    PCMC_PS_STBY = 3'h3,
    PCMC_PS_PDN  = 3'h4
  } pcmc_pwr_e;
  typedef enum logic [1:0] {
    PCMC_CM_CONT    = 2'h0,
    PCMC_CM_SINGLE  = 2'h1,
    PCMC_CM_ONESHOT = 2'h2,
    PCMC_CM_DUTY    = 2'h3
  } pcmc_conv_e;
  typedef enum logic [1:0] {
    PCMC_CS_IDLE = 2'h0,
    PCMC_CS_RUN  = 2'h1,
    PCMC_CS_REST = 2'h2
  } pcmc_cst_e;
endpackage

// [pcmc_clk_div.sv]
// modulator clock divider: master clock over 2, 4, 8 or 16
`timescale 1ns/1ps
module pcmc_clk_div (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  // control
  input  wire logic       i_en,
  input  wire logic [1:0] i_div_sel,
  // outputs
  output logic            o_mod_clk,
  output logic            o_tick
);
  logic [3:0] cnt;
  logic [3:0] half_last;

  // half period of 1, 2, 4 or 8 master clocks
  assign half_last = (4'h1 << i_div_sel) - 4'h1; // RL1

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b || !i_en) begin
      cnt       <= 4'h0;
      o_mod_clk <= 1'b0;
      o_tick    <= 1'b0;
    end else if (cnt >= half_last) begin
      cnt       <= 4'h0;
      o_mod_clk <= ~o_mod_clk; // RL1
      o_tick    <= ~o_mod_clk;
    end else begin
      cnt    <= cnt + 4'h1;
      o_tick <= 1'b0;
    end
  end
endmodule // pcmc_clk_div

// [pcmc_wake_det.sv]
// wake code detector, the only logic alive in power-down
`timescale 1ns/1ps
`include "pcmc_consts.svh"
module pcmc_wake_det (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  // serial sampling
  input  wire logic i_active,
  input  wire logic i_cs_b,
  input  wire logic i_rise,
  input  wire logic i_sdi,
  // result
  output logic      o_wake
);
  logic       seen_one;
  logic [5:0] zeros;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b || !i_active || i_cs_b) begin
      seen_one <= 1'b0;
      zeros    <= 6'h00;
      o_wake   <= 1'b0;
    end else if (i_rise) begin
      // a one restarts the count so a stray one cannot shorten the code
      if (i_sdi) begin
        seen_one <= 1'b1;
        zeros    <= 6'h00;
        o_wake   <= 1'b0;
      end else if (seen_one) begin
        zeros  <= zeros + 6'h01;
        o_wake <= (zeros == `PCMC_WAKE_ZEROS - 6'h01); // RL14
      end
    end else begin
      o_wake <= 1'b0;
    end
  end
endmodule // pcmc_wake_det

// [pcmc_top.sv]
// power, clock source and conversion mode control reached over the serial port
`timescale 1ns/1ps
`include "pcmc_consts.svh"
module pcmc_top
  import pcmc_pkg::*;
#(
  parameter logic [7:0] CONV_TICKS = `PCMC_CONV_TICKS
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  // strap and trigger
  input  wire logic        i_clock_sel,
  input  wire logic        i_start,
  // serial port
  input  wire logic        i_sclk,
  input  wire logic        i_cs_b,
  input  wire logic        i_sdi,
  output logic             o_sdo,
  output logic             o_sdo_oe,
  // modulator
  input  wire logic [23:0] i_sample,
  output logic             o_mod_clk,
  output logic             o_drdy,
  // power and clock source enables
  output logic             o_analog_en,
  output logic             o_ldo_en,
  output logic             o_src_cmos,
  output logic             o_src_xtal,
  output logic             o_src_lvds,
  output logic [2:0]       o_pwr_state,
  output logic             o_conv_busy
);
  logic        strap_q;
  logic        sclk_q;
  logic        cs_q;
  logic        start_q;
  logic [4:0]  bit_cnt;
  logic [15:0] rx_sh;
  logic [31:0] tx_sh;
  logic [7:0]  pwr_clk;
  logic [7:0]  ifmt;
  logic [7:0]  conv_cfg;
  logic [7:0]  duty;
  logic [23:0] result;
  logic        new_data;
  pcmc_cst_e   cst;
  logic [7:0]  tcnt;
  logic [15:0] rest_cnt;
  logic        tick;
  logic        wake;
  logic        single_done;

  logic        rise;
  logic        fall;
  logic        cs_fall;
  logic        start_rise;
  logic [15:0] next_word;
  logic        wr_stb;
  logic        rd_stb;
  logic        pdn;
  logic        analog_on;
  logic        crd;
  logic        conv_done;
  logic [7:0]  stat8;
  logic [31:0] stream_word;
  pcmc_pwr_e   pst;
  pcmc_conv_e  cmode;

  function automatic logic [7:0] pcmc_rd(input logic [6:0] addr, input logic [7:0] st);
    case (addr)
      `PCMC_ADDR_PWR_CLK: pcmc_rd = pwr_clk;
      `PCMC_ADDR_IFMT:    pcmc_rd = ifmt;
      `PCMC_ADDR_CONV:    pcmc_rd = conv_cfg;
      `PCMC_ADDR_DUTY:    pcmc_rd = duty;
      `PCMC_ADDR_STAT:    pcmc_rd = st;
      default:            pcmc_rd = 8'h00;
    endcase
  endfunction

  assign pst        = pcmc_pwr_e'(pwr_clk[`PCMC_PST_MSB:`PCMC_PST_LSB]);
  assign cmode      = pcmc_conv_e'(conv_cfg[`PCMC_MODE_MSB:`PCMC_MODE_LSB]);
  assign pdn        = (pst == PCMC_PS_PDN);
  // only fast, medium and low power run the modulator
  assign analog_on  = (pst == PCMC_PS_FAST) || (pst == PCMC_PS_MED) ||
                      (pst == PCMC_PS_LOW); // RL4
  assign crd        = ifmt[`PCMC_IF_CRD];
  assign rise       = i_sclk & ~sclk_q & ~i_cs_b;
  assign fall       = ~i_sclk & sclk_q & ~i_cs_b;
  assign cs_fall    = ~i_cs_b & cs_q;
  assign start_rise = i_start & ~start_q;
  assign next_word  = {rx_sh[14:0], i_sdi};
  // serial port is dead in power-down, only the wake detector listens
  assign wr_stb     = rise && (bit_cnt == `PCMC_WORD_LAST) && !next_word[15] && !pdn; // RL5
  assign rd_stb     = rise && (bit_cnt == `PCMC_CMD_LAST) && next_word[7] && !pdn && !crd;
  assign conv_done  = (cst == PCMC_CS_RUN) && tick && (tcnt == CONV_TICKS - 8'h01) &&
                      analog_on;
  assign stat8      = {pwr_clk[`PCMC_PST_MSB:`PCMC_PST_LSB], o_conv_busy, strap_q, o_src_lvds,
                       new_data, 1'b0};

  always_comb begin
    if (ifmt[`PCMC_IF_LEN16]) begin
      stream_word = {result[23:8], (ifmt[`PCMC_IF_STAT] ? stat8 : 8'h00), 8'h00}; // RL7 RL8
    end else begin
      stream_word = {result, (ifmt[`PCMC_IF_STAT] ? stat8 : 8'h00)}; // RL7 RL8
    end
  end

  // sampled inputs; the strap is caught only while reset is held
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      strap_q <= i_clock_sel;
      sclk_q  <= 1'b0;
      cs_q    <= 1'b1;
      start_q <= 1'b0;
    end else begin
      sclk_q  <= i_sclk;
      cs_q    <= i_cs_b;
      start_q <= i_start;
    end
  end

  // serial receive
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b || i_cs_b) begin
      bit_cnt <= 5'h00;
      rx_sh   <= 16'h0000;
    end else if (rise) begin
      rx_sh   <= next_word;
      bit_cnt <= (bit_cnt == `PCMC_WORD_LAST) ? 5'h00 : bit_cnt + 5'h01;
    end
  end

  // serial transmit: with continuous read set, results stream on every frame with no command needed
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      tx_sh    <= 32'h0000_0000;
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else if (i_cs_b || pdn) begin
      tx_sh    <= 32'h0000_0000;
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else if (cs_fall && crd) begin
      o_sdo    <= stream_word[31]; // RL9
      tx_sh    <= {stream_word[30:0], 1'b0};
      o_sdo_oe <= 1'b1;
    end else if (rd_stb) begin
      tx_sh    <= {pcmc_rd(next_word[6:0], stat8), 24'h00_0000};
      o_sdo_oe <= 1'b1;
    end else if (fall) begin
      o_sdo    <= tx_sh[31];
      tx_sh    <= {tx_sh[30:0], 1'b0};
      o_sdo_oe <= 1'b1;
    end
  end

  // power/clock register; the wake code brings back reset values
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b || wake) begin
      pwr_clk <= `PCMC_PWR_CLK_RST; // RL14
    end else if (single_done) begin
      pwr_clk[`PCMC_PST_MSB:`PCMC_PST_LSB] <= PCMC_PS_STBY; // RL10
    end else if (wr_stb && next_word[14:8] == `PCMC_ADDR_PWR_CLK) begin
      pwr_clk <= next_word[7:0]; // RL4
    end
  end

  // other settings are lost in power-down, kept in standby
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b || pdn) begin
      ifmt     <= `PCMC_IFMT_RST; // RL5
      conv_cfg <= `PCMC_CONV_RST;
      duty     <= `PCMC_DUTY_RST;
    end else if (wr_stb) begin
      if (next_word[14:8] == `PCMC_ADDR_IFMT) begin
        ifmt <= next_word[7:0];
      end
      if (next_word[14:8] == `PCMC_ADDR_CONV) begin
        conv_cfg <= next_word[7:0];
      end
      if (next_word[14:8] == `PCMC_ADDR_DUTY) begin
        duty <= next_word[7:0];
      end
    end
  end

  // conversion sequencer
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b || !analog_on) begin
      cst         <= PCMC_CS_IDLE;
      tcnt        <= 8'h00;
      rest_cnt    <= 16'h0000;
      single_done <= 1'b0;
    end else begin
      single_done <= 1'b0;
      case (cst)
        PCMC_CS_IDLE: begin
          tcnt <= 8'h00;
          if (cmode != PCMC_CM_ONESHOT || start_rise) begin
            cst <= PCMC_CS_RUN; // RL11
          end
        end
        PCMC_CS_RUN: begin
          if (tick) begin
            tcnt <= conv_done ? 8'h00 : tcnt + 8'h01;
          end
          if (conv_done) begin
            case (cmode)
              PCMC_CM_CONT: cst <= PCMC_CS_RUN; // RL12
              PCMC_CM_SINGLE: begin
                cst         <= PCMC_CS_IDLE;
                single_done <= 1'b1; // RL10
              end
              PCMC_CM_ONESHOT: cst <= PCMC_CS_IDLE; // RL11
              PCMC_CM_DUTY: begin
                cst      <= PCMC_CS_REST; // RL13
                rest_cnt <= {duty, 8'h00};
              end
              default: cst <= PCMC_CS_IDLE;
            endcase
          end
        end
        PCMC_CS_REST: begin
          // interval counted in master clocks since the modulator clock is stopped
          if (rest_cnt == 16'h0000) begin
            cst <= PCMC_CS_RUN; // RL13
          end else begin
            rest_cnt <= rest_cnt - 16'h0001;
          end
        end
        default: cst <= PCMC_CS_IDLE;
      endcase
    end
  end

  // result capture and data ready
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b || pdn) begin
      result   <= 24'h00_0000;
      new_data <= 1'b0;
      o_drdy   <= 1'b0;
    end else begin
      o_drdy <= conv_done;
      if (conv_done) begin
        result   <= i_sample;
        new_data <= 1'b1; // set wins over the frame clear
      end else if (cs_fall && crd) begin
        new_data <= 1'b0;
      end
    end
  end

  // power and clock source enables
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_analog_en <= 1'b0;
      o_ldo_en    <= 1'b0;
      o_src_cmos  <= 1'b0;
      o_src_xtal  <= 1'b0;
      o_src_lvds  <= 1'b0;
      o_pwr_state <= 3'h0;
      o_conv_busy <= 1'b0;
    end else begin
      o_analog_en <= analog_on && cst != PCMC_CS_REST; // RL6 RL13
      o_ldo_en    <= !pdn; // RL5 RL6
      o_src_cmos  <= !strap_q && !pdn; // RL2
      o_src_lvds  <= strap_q && !pdn &&
                     pwr_clk[`PCMC_SRC_MSB:`PCMC_SRC_LSB] == `PCMC_SRC_LVDS; // RL3
      o_src_xtal  <= strap_q && !pdn &&
                     pwr_clk[`PCMC_SRC_MSB:`PCMC_SRC_LSB] != `PCMC_SRC_LVDS; // RL2
      o_pwr_state <= pwr_clk[`PCMC_PST_MSB:`PCMC_PST_LSB];
      o_conv_busy <= (cst == PCMC_CS_RUN);
    end
  end

  pcmc_clk_div u_div (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_en       (analog_on && cst != PCMC_CS_REST),
    .i_div_sel  (pwr_clk[`PCMC_DIV_MSB:`PCMC_DIV_LSB]),
    .o_mod_clk  (o_mod_clk),
    .o_tick     (tick)
  );

  pcmc_wake_det u_wake (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_active   (pdn),
    .i_cs_b     (i_cs_b),
    .i_rise     (rise),
    .i_sdi      (i_sdi),
    .o_wake     (wake)
  );

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  AST_CMOS_STRAP: assert property (!strap_q && !pdn |=> o_src_cmos) // RL2
    else $error("cmos source not enabled with strap low");
  AST_LVDS_GATED: assert property (o_src_lvds |-> $past(strap_q) && // RL3
    $past(pwr_clk[`PCMC_SRC_MSB:`PCMC_SRC_LSB]) == `PCMC_SRC_LVDS)
    else $error("lvds enabled without strap and register select");
  AST_PDN_OFF: assert property (pdn |=> !o_analog_en && !o_ldo_en && !o_sdo_oe) // RL5
    else $error("blocks still on in power-down");
  AST_PDN_LOST: assert property (pdn |=> ifmt == `PCMC_IFMT_RST && // RL5
    conv_cfg == `PCMC_CONV_RST && duty == `PCMC_DUTY_RST)
    else $error("settings kept through power-down");
  AST_STBY_KEEP: assert property (pst == PCMC_PS_STBY && !wr_stb |=> // RL6
    o_ldo_en && !o_analog_en && $stable(ifmt) && $stable(duty))
    else $error("standby lost settings or kept analog on");
  AST_SINGLE_STBY: assert property (conv_done && cmode == PCMC_CM_SINGLE |=> // RL10
    ##1 pst == PCMC_PS_STBY ##1 cst == PCMC_CS_IDLE)
    else $error("single conversion did not return to standby");
  AST_CONT_RUN: assert property (conv_done && cmode == PCMC_CM_CONT && analog_on |=> // RL12
    cst == PCMC_CS_RUN)
    else $error("continuous mode stopped converting");
  AST_DUTY_REST: assert property (conv_done && cmode == PCMC_CM_DUTY |=> // RL13
    cst == PCMC_CS_REST ##1 !o_analog_en)
    else $error("duty cycle did not rest in standby");
  AST_ONESHOT_WAIT: assert property (cst == PCMC_CS_IDLE && // RL11
    cmode == PCMC_CM_ONESHOT && !start_rise && analog_on |=> cst == PCMC_CS_IDLE)
    else $error("one-shot converted without a pulse");
  AST_WAKE_RESET: assert property (wake |=> pwr_clk == `PCMC_PWR_CLK_RST) // RL14
    else $error("wake code did not leave power-down");
  AST_DRDY_PULSE: assert property (conv_done |=> o_drdy && result == $past(i_sample)) // RL9
    else $error("result not captured on conversion end");
endmodule // pcmc_top

// [pcmc_host.sv]
// host controller model: serial master, one-shot trigger and wake sequence
`timescale 1ns/1ps
module pcmc_host #(
  parameter int HALF = 4
) (
  // clock
  input  wire logic i_core_clk,
  // serial port
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  output logic      o_sclk,
  output logic      o_cs_b,
  output logic      o_sdi,
  // trigger
  output logic      o_start
);
  logic oe_seen;

  initial begin
    o_sclk  = 1'b0;
    o_cs_b  = 1'b1;
    o_sdi   = 1'b1;
    o_start = 1'b0;
    oe_seen = 1'b0;
  end

  // mode 0, msb first; data moves only while sclk is low, sclk still outside frames
  task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    @(posedge i_core_clk);
    o_cs_b <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdi <= tx[i];
      repeat (HALF) @(posedge i_core_clk);
      o_sclk <= 1'b1;
      rx = {rx[62:0], i_sdo};
      oe_seen = oe_seen | i_sdo_oe;
      repeat (HALF) @(posedge i_core_clk);
      o_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge i_core_clk);
    o_cs_b <= 1'b1;
    // no pull on the line, so a released sdi shows the inverse of its last bit
    o_sdi <= ~tx[0];
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    logic [63:0] rx;
    frame(16, {48'h0, 1'b0, a, d}, rx);
  endtask

  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    logic [63:0] rx;
    frame(16, {48'h0, 1'b1, a, 8'h00}, rx);
    d = rx[7:0];
  endtask

  task automatic stream(output logic [31:0] w);
    logic [63:0] rx;
    frame(32, 64'h0, rx);
    w = rx[31:0];
  endtask

  task automatic wake_code();
    logic [63:0] rx;
    frame(64, {1'b1, 63'h0}, rx);
  endtask

  task automatic pulse_start();
    @(posedge i_core_clk);
    o_start <= 1'b1;
    repeat (HALF) @(posedge i_core_clk);
    o_start <= 1'b0;
  endtask
endmodule // pcmc_host

// [tb_power_clock_mode_control.sv]
// self-checking bench for the power, clock source and conversion mode block
`timescale 1ns/1ps
module tb_power_clock_mode_control;
  import pcmc_pkg::*;
  localparam int LIMIT = 30000;
  logic        i_core_clk, i_rst_b, i_clock_sel;
  logic        sclk, cs_b, sdi, start, sdo, sdo_oe, mod_clk, drdy;
  logic        analog_en, ldo_en, src_cmos, src_xtal, src_lvds, conv_busy;
  logic [2:0]  pwr_state;
  logic [7:0]  rd;
  logic [31:0] w;
  logic [63:0] rx;
  logic [23:0] sample;
  int          error_cnt, checks, cycles, drdy_total, c0;
  logic [23:0] smp [3]      = '{24'hA5C396, 24'h5A3C69, 24'h123456};
  logic [6:0]  rst_addr [5] = '{7'h15, 7'h16, 7'h17, 7'h18, 7'h20};
  logic [7:0]  rst_val [5]  = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
  logic [7:0]  fmt [3]      = '{8'h04, 8'h06, 8'h07};
  logic [31:0] fmt_mask [3] = '{32'hFFFFFFFF, 32'hFFFFFFEF, 32'hFFFFEFFF};
  logic [31:0] fmt_exp [3]  = '{32'hA5C39600, 32'h5A3C6902, 32'h12340200};

  initial i_core_clk = 1'b0;
  always #50 i_core_clk = ~i_core_clk;

  pcmc_top #(.CONV_TICKS(8'h04)) dut (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_clock_sel(i_clock_sel),
    .i_start(start), .i_sclk(sclk), .i_cs_b(cs_b), .i_sdi(sdi), .o_sdo(sdo),
    .o_sdo_oe(sdo_oe), .i_sample(sample), .o_mod_clk(mod_clk), .o_drdy(drdy),
    .o_analog_en(analog_en), .o_ldo_en(ldo_en), .o_src_cmos(src_cmos),
    .o_src_xtal(src_xtal), .o_src_lvds(src_lvds), .o_pwr_state(pwr_state),
    .o_conv_busy(conv_busy));

  pcmc_host host (
    .i_core_clk(i_core_clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_sclk(sclk),
    .o_cs_b(cs_b), .o_sdi(sdi), .o_start(start));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge i_core_clk);
    i_rst_b     <= 1'b0;
    i_clock_sel <= strap;
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_core_clk);
  endtask

  // hang guard plus a running count of result pulses
  always @(posedge i_core_clk) begin
    cycles++;
    if (drdy === 1'b1) drdy_total++;
    if (cycles == LIMIT) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    i_rst_b = 1'b0;
    i_clock_sel = 1'b0;
    sample = 24'hA5C396;
    do_reset(1'b0);
    foreach (rst_addr[i]) begin
      host.read_reg(rst_addr[i], rd);
      check("reset value", rd, rst_val[i]);
    end
    check("cmos source", src_cmos, 1'b1);
    host.write_reg(7'h15, 8'hC0);
    repeat (2) @(posedge i_core_clk);
    check("lvds needs strap", {src_cmos, src_lvds}, 2'b10);
    for (int d = 0; d < 4; d++) begin
      host.write_reg(7'h15, 8'(d << 4));
      @(posedge mod_clk);
      @(posedge mod_clk);
      c0 = cycles;
      @(posedge mod_clk);
      check("mod period", cycles - c0, 2 << d);
    end
    host.write_reg(7'h15, 8'h00);
    @(posedge drdy);
    c0 = cycles;
    @(posedge drdy);
    check("continuous gap", cycles - c0, 8);
    host.read_reg(7'h19, rd);
    check("status busy and new data", rd, 8'h12);
    check("busy in continuous", conv_busy, 1'b1);
    host.write_reg(7'h16, 8'h03);
    for (int s = 0; s < 4; s++) begin
      host.write_reg(7'h15, 8'(s));
      repeat (2) @(posedge i_core_clk);
      check("power state", pwr_state, s);
      check("analog on", analog_en, s != 3);
      check("regulator on", ldo_en, 1'b1);
    end
    check("standby mod clk", mod_clk, 1'b0);
    host.read_reg(7'h16, rd);
    check("kept in standby", rd, 8'h03);
    check("port drives in standby", host.oe_seen, 1'b1);
    host.write_reg(7'h15, 8'h00);
    foreach (fmt[i]) begin
      sample <= smp[i];
      host.write_reg(7'h16, fmt[i]);
      repeat (20) @(posedge i_core_clk);
      host.stream(w);
      check("stream word", w & fmt_mask[i], fmt_exp[i]);
    end
    host.write_reg(7'h16, 8'h00);
    host.write_reg(7'h15, 8'h03);
    host.write_reg(7'h17, 8'h01);
    c0 = drdy_total;
    host.write_reg(7'h15, 8'h00);
    repeat (200) @(posedge i_core_clk);
    check("single count", drdy_total - c0, 1);
    check("single to standby", pwr_state, 3'h3);
    host.write_reg(7'h17, 8'h02);
    host.write_reg(7'h15, 8'h00);
    c0 = drdy_total;
    repeat (100) @(posedge i_core_clk);
    check("no trigger", drdy_total - c0, 0);
    check("idle until trigger", conv_busy, 1'b0);
    host.pulse_start();
    repeat (100) @(posedge i_core_clk);
    check("one per trigger", drdy_total - c0, 1);
    host.write_reg(7'h18, 8'h01);
    host.write_reg(7'h17, 8'h03);
    @(posedge drdy);
    @(posedge drdy);
    c0 = cycles;
    repeat (4) @(posedge i_core_clk);
    check("rest analog off", analog_en, 1'b0);
    @(posedge drdy);
    check("duty gap", (cycles - c0 >= 264) && (cycles - c0 <= 272), 1'b1);
    host.write_reg(7'h17, 8'h00);
    host.write_reg(7'h16, 8'h02);
    host.write_reg(7'h15, 8'h04);
    repeat (4) @(posedge i_core_clk);
    check("pd power", {ldo_en, analog_en}, 2'b00);
    check("pd clocks", {src_cmos, src_xtal, src_lvds, mod_clk}, 4'h0);
    host.read_reg(7'h15, rd);
    check("pd port silent", host.oe_seen, 1'b0);
    host.frame(32, 64'h80000000, rx);
    check("short code", pwr_state, 3'h4);
    host.wake_code();
    repeat (4) @(posedge i_core_clk);
    check("woken", {pwr_state, ldo_en}, 4'h1);
    host.read_reg(7'h16, rd);
    check("format lost", rd, 8'h00);
    do_reset(1'b1);
    check("crystal", {src_cmos, src_xtal, src_lvds}, 3'b010);
    host.write_reg(7'h15, 8'hC0);
    repeat (2) @(posedge i_core_clk);
    check("lvds", {src_cmos, src_xtal, src_lvds}, 3'b001);
    wrap_up();
  end
endmodule // tb_power_clock_mode_control
